// File: dv/art_timer_far.sv
// Purpose: Far-side model that drives the external clock and capture pins of the timer.
// Assumes: Pins change just after a rising pclk edge and far slower than pclk/2.
// Notes:   The external clock stands low between bursts; capture pins hold their level.
`timescale 1ns/100ps
module art_timer_far (
  // Clock of the bench.
  input  wire logic                      pclk,
  // Pins into the timer.
  output logic                           ext_clk_in,
  output logic [1:0]                     capture_input_pin,
  // PWM pins as seen from the board.
  input  wire art_timer_pkg::pwm_pins_t  pulse_output_pin
);
  import art_timer_pkg::*;

  // Pin 1 idles high so that its first edge can be a falling one.
  initial begin
    ext_clk_in        = 1'b0;
    capture_input_pin = 2'b10;
  end

  // Pulses are four cycles high and five low between them, so the synchroniser never misses one.
  task automatic ext_pulses(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      ext_clk_in <= 1'b1;
      repeat (4) @(posedge pclk);
      ext_clk_in <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  endtask

  // Holds the new level long enough to pass synchronisation and edge detection.
  task automatic cap_set(input int ch, input logic lvl);
    @(posedge pclk);
    capture_input_pin[ch] <= lvl;
    repeat (8) @(posedge pclk);
  endtask
endmodule

// File: dv/auto_reload_pwm_capture_timer_tb.sv
// Purpose: Self-checking bench for the auto-reload PWM and capture timer.
// Assumes: APB master on pclk; the far-side model owns the external pins.
// Notes:   Counts are read twice 128 cycles apart, a gap that holds only while the slave adds no wait states.
`timescale 1ns/100ps
module auto_reload_pwm_capture_timer_tb;
  import art_timer_pkg::*;

  // Design inputs, outputs and bench bookkeeping.
  logic        pclk, presetn, psel, penable, pwrite, halt_mode;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic        pready, pslverr, timer_irq, wake_req, ext_clk_in, err;
  logic [1:0]  capture_input_pin;
  pwm_pins_t   pins;
  int          failures, check_count;

  art_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .halt_mode(halt_mode), .timer_irq(timer_irq), .wake_req(wake_req),
    .ext_clk_in(ext_clk_in), .capture_input_pin(capture_input_pin),
    .pulse_output_pin(pins));
  art_timer_far far (.pclk(pclk), .ext_clk_in(ext_clk_in),
    .capture_input_pin(capture_input_pin), .pulse_output_pin(pins));

  // Free-running 125 MHz clock.
  always #4 pclk = ~pclk;

  task automatic tally_and_finish();
    if (failures == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; the request stands until pready is sampled high.
  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {20'h0, idx, 2'b00};
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      failures++;
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rdc(input logic [9:0] idx, input logic [7:0] e, input string name);
    apb(1'b0, idx, 8'h00);
    chk(name, rd, {24'h0, e});
  endtask

  // Sample away from the edge so that flag updates have landed.
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic t_reset();
    for (int i = 'h73; i <= 'h7D; i++) begin
      rdc(i[9:0], 8'h00, "reset_value");
    end
    apb(1'b0, 10'h072, 8'h00);
    chk("unmapped_err", err, 1'b1);
  endtask

  task automatic t_divider();
    logic [31:0] c1;
    for (int k = 0; k < 8; k++) begin
      wr(IDX_CSR, {1'b0, k[2:0], 4'h8});
      wr(IDX_CNT, 8'h00);
      apb(1'b0, IDX_CNT, 8'h00);
      c1 = rd;
      repeat (125) @(posedge pclk);
      apb(1'b0, IDX_CNT, 8'h00);
      chk("count_step", (rd - c1) & 32'hFF, 32'd128 >> k);
    end
  endtask

  task automatic t_overflow();
    wr(IDX_RELOAD, 8'hF0);
    wr(IDX_CNT, 8'hFE);
    wr(IDX_CSR, 8'h08);
    settle(20);
    chk("ovf_masked", timer_irq, 1'b0);
    wr(IDX_CSR, 8'h0A);
    settle(1);
    chk("ovf_irq", timer_irq, 1'b1);
    wr(IDX_CSR, 8'h02);
    apb(1'b0, IDX_CNT, 8'h00);
    chk("reload_range", rd[7:0] >= 8'hF0, 1'b1);
    wr(IDX_CSR, 8'h06);
    rdc(IDX_CNT, 8'hF0, "forced_load");
    rdc(IDX_CSR, 8'h03, "csr_ovf_set");
    rdc(IDX_CSR, 8'h02, "csr_ovf_clear");
    settle(1);
    chk("irq_clear", timer_irq, 1'b0);
  endtask

  task automatic t_pwm();
    wr(IDX_RELOAD, 8'h00);
    wr(IDX_DUTY0, 8'h80);
    wr(IDX_DUTY0 - 10'h1, 8'h10);
    wr(IDX_DUTY0 - 10'h2, 8'h60);
    wr(IDX_DUTY3, 8'hFF);
    wr(IDX_PWMCTL, 8'hF0);
    wr(IDX_CSR, 8'h08);
    repeat (300) @(posedge pclk);
    wr(IDX_CSR, 8'h00);
    wr(IDX_CNT, 8'h50);
    settle(2);
    chk("pwm_levels", pins, 8'hDF);
    wr(IDX_PWMCTL, 8'hF5);
    settle(1);
    chk("pwm_polarity", pins, 8'h8F);
    wr(IDX_DUTY0, 8'h10);
    settle(2);
    chk("pwm_duty_buffered", pins, 8'h8F);
    wr(IDX_PWMCTL, 8'h30);
    settle(2);
    chk("pwm_enable", pins, 8'h13);
  endtask

  task automatic t_capture();
    wr(IDX_CNT, 8'h33);
    wr(IDX_CAPCSR, 8'h14);
    far.cap_set(0, 1'b1);
    settle(1);
    chk("cap_irq", timer_irq, 1'b1);
    rdc(IDX_CAPCSR, 8'h15, "cap_flag1");
    wr(IDX_CNT, 8'h44);
    far.cap_set(0, 1'b0);
    far.cap_set(0, 1'b1);
    rdc(IDX_CAP1, 8'h33, "cap_data1");
    settle(1);
    chk("cap_irq_clear", timer_irq, 1'b0);
    far.cap_set(1, 1'b0);
    settle(1);
    chk("cap_irq_masked", timer_irq, 1'b0);
    rdc(IDX_CAPCSR, 8'h16, "cap_flag2");
    rdc(IDX_CAP2, 8'h44, "cap_data2");
    wr(IDX_CAPCSR, 8'hFF);
    rdc(IDX_CAPCSR, 8'h3C, "cap_reserved");
  endtask

  task automatic t_halt();
    wr(IDX_CAPCSR, 8'h00);
    wr(IDX_RELOAD, 8'hFE);
    wr(IDX_CNT, 8'hFE);
    wr(IDX_CSR, 8'h8A);
    @(posedge pclk);
    halt_mode <= 1'b1;
    wr(IDX_CSR, 8'h00);
    far.ext_pulses(2);
    settle(1);
    chk("halt_wake", wake_req, 1'b1);
    @(posedge pclk);
    halt_mode <= 1'b0;
    rdc(IDX_CSR, 8'h8B, "halt_frozen");
    rdc(IDX_CNT, 8'hFE, "ext_count");
    wr(IDX_CSR, 8'h00);
    wr(IDX_CAPCSR, 8'h04);
    @(posedge pclk);
    halt_mode <= 1'b1;
    far.cap_set(0, 1'b0);
    settle(1);
    chk("cap_wake", wake_req, 1'b1);
    @(posedge pclk);
    halt_mode <= 1'b0;
  endtask

  // Main sequence: reset for six cycles, then each scenario in turn.
  initial begin
    pclk        = 1'b0;
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 32'h0;
    pwdata      = 32'h0;
    halt_mode   = 1'b0;
    failures    = 0;
    check_count = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_divider();
    t_overflow();
    t_pwm();
    t_capture();
    t_halt();
    tally_and_finish();
  end
endmodule

// File: hw/art_timer.sv
// Purpose: Auto-reload 8-bit timer with prescaler, four PWM outputs and two captures.
// Assumes: APB slave with no wait states; halt_mode comes from logic on pclk.
// Notes:   External clock and capture pins are sampled, so they must be slower than pclk/2.
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/100ps
module art_timer (
  // APB slave.
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Power mode and wake.
  input  wire logic                      halt_mode,
  output logic                           timer_irq,
  output logic                           wake_req,
  // External pins.
  input  wire logic                      ext_clk_in,
  input  wire logic [1:0]                capture_input_pin,
  output art_timer_pkg::pwm_pins_t       pulse_output_pin
);
  import art_timer_pkg::*;

  state_t st_r;
  state_t st_nxt;

  // Mask of the prescaler tap chosen by the divider field.
  function automatic logic [6:0] tap_mask(input logic [2:0] div);
    logic [7:0] m;
    m = (8'h01 << div) - 8'h01;
    return m[6:0];
  endfunction

  // True for an index that holds a register.
  function automatic logic idx_mapped(input logic [9:0] idx);
    return (idx >= IDX_DUTY3) && (idx <= IDX_CAP2);
  endfunction

  logic [9:0] idx;
  logic       acc_wr;
  logic       acc_rd;
  logic       setup;
  logic       in_tick;
  logic       cnt_tick;
  logic       ovf_evt;
  logic       ext_rise;
  logic [1:0] cap_edge_hit;
  logic [1:0] cap_read;
  logic       csr_read;
  logic       wr_ok;
  logic       halted_ext;

  // Bus decode; the read word is latched in setup so prdata comes from a flop.
  assign idx    = paddr[11:2];
  assign setup  = psel && !penable;
  assign acc_wr = psel && penable && pwrite && !st_r.err;
  assign acc_rd = psel && penable && !pwrite && !st_r.err;
  assign wr_ok  = acc_wr && !halt_mode;
  assign csr_read = acc_rd && (idx == IDX_CSR);
  assign cap_read[0] = acc_rd && (idx == IDX_CAP1);
  assign cap_read[1] = acc_rd && (idx == IDX_CAP2);
  assign halted_ext  = halt_mode && st_r.ext_clock_select;

  // Edge detectors look only at the second and third sync stages.
  assign ext_rise = st_r.ext_sync[1] && !st_r.ext_sync[2];
  always_comb begin
    for (int c = 0; c < CAP_CHANS; c++) begin
      cap_edge_hit[c] = st_r.cap_edge[c] ?
                        (st_r.cap_sync[c][1] && !st_r.cap_sync[c][2]) :
                        (!st_r.cap_sync[c][1] && st_r.cap_sync[c][2]);
    end
  end

  // Input tick: CPU clock every cycle, else a synchronised external rising edge.
  // With the CPU clock selected the counter sleeps in halt, since halt_mode masks the tick there.
  assign in_tick  = st_r.counter_run_enable &&
                    (st_r.ext_clock_select ? ext_rise : !halt_mode);
  assign cnt_tick = in_tick &&
                    ((st_r.presc & tap_mask(st_r.counter_clock_divider)) ==
                     tap_mask(st_r.counter_clock_divider));
  assign ovf_evt  = cnt_tick && (st_r.cnt == CNT_TOP) &&
                    !(wr_ok && (idx == IDX_CNT));

  // Next-state logic for the whole timer.
  always_comb begin
    st_nxt = st_r;
    // Synchronisers for pins from outside the clock domain.
    st_nxt.ext_sync = {st_r.ext_sync[1:0], ext_clk_in};
    for (int c = 0; c < CAP_CHANS; c++) begin
      st_nxt.cap_sync[c] = {st_r.cap_sync[c][1:0], capture_input_pin[c]};
    end

    // Prescaler and counter.
    if (in_tick) begin
      st_nxt.presc = st_r.presc + 7'h01;
    end
    if (cnt_tick) begin
      if (st_r.cnt == CNT_TOP) begin
        st_nxt.cnt = st_r.reload;
        st_nxt.compare_shadow = st_r.duty;
      end else begin
        st_nxt.cnt = st_r.cnt + 8'h01;
      end
    end

    // Overflow flag: a set in the same cycle as the clearing read wins.
    if (csr_read) begin
      st_nxt.overflow_flag = 1'b0;
    end
    if (ovf_evt) begin
      st_nxt.overflow_flag = 1'b1;
    end

    // Capture flags and data; a capture beats the clearing read of old data.
    for (int c = 0; c < CAP_CHANS; c++) begin
      if (cap_read[c]) begin
        st_nxt.capture_flag[c] = 1'b0;
      end
      if (cap_edge_hit[c] && (!st_r.capture_flag[c] || cap_read[c])) begin
        st_nxt.capture_data[c] = st_r.cnt;
        st_nxt.capture_flag[c] = 1'b1;
      end
    end

    // Register writes, ignored while the processor is halted.
    if (wr_ok) begin
      case (idx)
        IDX_CSR: begin
          st_nxt.ext_clock_select      = pwdata[CSR_EXT_CLOCK_SELECT_BIT];
          st_nxt.counter_clock_divider = pwdata[CSR_DIV_LSB +: 3];
          st_nxt.counter_run_enable    = pwdata[CSR_RUN_BIT];
          st_nxt.overflow_irq_enable   = pwdata[CSR_OIE_BIT];
          if (pwdata[CSR_FRL_BIT]) begin
            st_nxt.cnt   = st_r.reload;
            st_nxt.presc = PRESC_RST;
          end
        end
        IDX_CNT: begin
          st_nxt.cnt   = pwdata[7:0];
          st_nxt.presc = PRESC_RST;
        end
        IDX_RELOAD: begin
          st_nxt.reload = pwdata[7:0];
        end
        IDX_PWMCTL: begin
          st_nxt.out_enable       = pwdata[7:4];
          st_nxt.channel_polarity = pwdata[3:0];
        end
        IDX_CAPCSR: begin
          st_nxt.cap_edge           = pwdata[CAP_EDGE_LSB +: 2];
          st_nxt.capture_irq_enable = pwdata[CAP_IE_LSB +: 2];
        end
        default: begin
          for (int k = 0; k < PWM_CHANS; k++) begin
            if (idx == IDX_DUTY0 - 10'(k)) begin
              st_nxt.duty[k] = pwdata[7:0];
            end
          end
        end
      endcase
    end

    // PWM levels follow the next count, compare and polarity, so an overflow
    // and a polarity write both show on the pin one cycle later.
    for (int k = 0; k < PWM_CHANS; k++) begin
      st_nxt.pwm[k] = (st_nxt.cnt <= st_nxt.compare_shadow[k]) ^
                      st_nxt.channel_polarity[k];
    end

    // Read word and error are latched in the setup cycle.
    if (setup) begin
      st_nxt.err   = !idx_mapped(idx) || (paddr[1:0] != 2'b00) || (paddr[31:12] != 20'h0);
      st_nxt.rdata = 32'h0000_0000;
      case (idx)
        IDX_CSR: begin
          st_nxt.rdata[7:0] = {st_r.ext_clock_select, st_r.counter_clock_divider,
                               st_r.counter_run_enable, 1'b0,
                               st_r.overflow_irq_enable, st_r.overflow_flag};
        end
        IDX_CNT:    st_nxt.rdata[7:0] = st_r.cnt;
        IDX_RELOAD: st_nxt.rdata[7:0] = st_r.reload;
        IDX_PWMCTL: st_nxt.rdata[7:0] = {st_r.out_enable, st_r.channel_polarity};
        IDX_CAPCSR: begin
          st_nxt.rdata[7:0] = {2'b00, st_r.cap_edge,
                               st_r.capture_irq_enable, st_r.capture_flag};
        end
        IDX_CAP1:   st_nxt.rdata[7:0] = st_r.capture_data[0];
        IDX_CAP2:   st_nxt.rdata[7:0] = st_r.capture_data[1];
        default: begin
          for (int k = 0; k < PWM_CHANS; k++) begin
            if (idx == IDX_DUTY0 - 10'(k)) begin
              st_nxt.rdata[7:0] = st_r.duty[k];
            end
          end
        end
      endcase
    end
  end

  // State register; every field clears on reset except pwm, which loads PWM_RST.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r     <= '0;
      st_r.pwm <= PWM_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs.
  assign prdata  = st_r.rdata;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && st_r.err;
  assign timer_irq = (st_r.overflow_flag && st_r.overflow_irq_enable) ||
                     |(st_r.capture_flag & st_r.capture_irq_enable);
  // Wake only makes sense in halt; the overflow source only counts with fEXT.
  assign wake_req  = halt_mode &&
                     ((halted_ext && st_r.overflow_flag && st_r.overflow_irq_enable) ||
                      |(st_r.capture_flag & st_r.capture_irq_enable));
  assign pulse_output_pin.level = st_r.pwm & st_r.out_enable;
  assign pulse_output_pin.oe    = st_r.out_enable;

  // Checks on the logic above.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_halt_wr;
    halted_ext && acc_wr;
  endsequence

  frozen_in_halt_a: assert property (s_halt_wr |=> $stable(st_r.reload) && $stable(st_r.duty)
    && $stable(st_r.channel_polarity))
    else $error("Control register changed during halt.");

  halt_ovf_wake_a: assert property (halted_ext && st_r.overflow_irq_enable && ovf_evt
    && !csr_read ##1 halt_mode |-> wake_req)
    else $error("No wake on overflow in halt.");

  capture_copy_a: assert property (cap_edge_hit[0] && !st_r.capture_flag[0] |=>
    st_r.capture_flag[0] && (st_r.capture_data[0] == $past(st_r.cnt)))
    else $error("Capture did not copy the counter.");

  cap_irq_hold_a: assert property (st_r.capture_flag[1] && st_r.capture_irq_enable[1]
    |-> timer_irq)
    else $error("Capture interrupt dropped while flag set.");

  cap_blocked_a: assert property (st_r.capture_flag[0] && !cap_read[0]
    |=> $stable(st_r.capture_data[0]))
    else $error("Capture data overwritten before read.");

  ext_irq_wake_a: assert property (halt_mode && st_r.capture_flag[0]
    && st_r.capture_irq_enable[0] |-> wake_req)
    else $error("Capture channel failed to wake.");

  run_hold_a: assert property (!st_r.counter_run_enable && !wr_ok [*2]
    |-> $stable(st_r.cnt) && $stable(st_r.presc))
    else $error("Counter moved while stopped.");

  force_reload_a: assert property (wr_ok && (idx == IDX_CSR) && pwdata[CSR_FRL_BIT]
    |=> (st_r.cnt == $past(st_r.reload)) && (st_r.presc == PRESC_RST))
    else $error("Forced reload did not load the counter.");

  ovf_reload_a: assert property (ovf_evt |=> st_r.overflow_flag
    && (st_r.cnt == $past(st_r.reload)) && (st_r.compare_shadow == $past(st_r.duty)))
    else $error("Overflow did not reload and set the flag.");

  pol_flip_a: assert property (wr_ok && (idx == IDX_PWMCTL) && !cnt_tick
    && (pwdata[0] != st_r.channel_polarity[0]) |=> (st_r.pwm[0] != $past(st_r.pwm[0])))
    else $error("Polarity change did not invert the output.");

  // Further checks, one rule or channel at a time.
  ovf_flag_clr_a: assert property (csr_read && !ovf_evt |=> !st_r.overflow_flag)
    else $error("Overflow flag not cleared by status read.");

  ovf_irq_on_a: assert property (st_r.overflow_flag && st_r.overflow_irq_enable
    |-> timer_irq)
    else $error("Overflow request missing.");

  irq_quiet_a: assert property (!st_r.overflow_flag && !st_r.capture_irq_enable[0]
    && !st_r.capture_irq_enable[1] |-> !timer_irq)
    else $error("Request raised with sources masked.");

  cap_irq_ch0_a: assert property (st_r.capture_flag[0] && st_r.capture_irq_enable[0]
    |-> timer_irq)
    else $error("Capture request dropped on channel one.");

  cap_clr_ch0_a: assert property (cap_read[0] && !cap_edge_hit[0]
    |=> !st_r.capture_flag[0])
    else $error("Capture flag one not cleared by data read.");

  cap_clr_ch1_a: assert property (cap_read[1] && !cap_edge_hit[1]
    |=> !st_r.capture_flag[1])
    else $error("Capture flag two not cleared by data read.");

  cap_copy_ch1_a: assert property (cap_edge_hit[1] && !st_r.capture_flag[1] |=>
    st_r.capture_flag[1] && (st_r.capture_data[1] == $past(st_r.cnt)))
    else $error("Capture two did not copy the counter.");

  cap_block_ch1_a: assert property (st_r.capture_flag[1] && !cap_read[1]
    |=> $stable(st_r.capture_data[1]))
    else $error("Capture two overwritten before read.");

  cnt_write_a: assert property (wr_ok && (idx == IDX_CNT) |=>
    (st_r.cnt == $past(pwdata[7:0])) && (st_r.presc == PRESC_RST))
    else $error("Counter write did not land.");

  cnt_step_a: assert property (cnt_tick && (st_r.cnt != CNT_TOP) && !wr_ok
    |=> st_r.cnt == $past(st_r.cnt) + 8'h01)
    else $error("Counter did not advance by one.");

  presc_step_a: assert property (in_tick && !wr_ok
    |=> st_r.presc == $past(st_r.presc) + 7'h01)
    else $error("Prescaler did not advance.");

  div_one_a: assert property (in_tick && (st_r.counter_clock_divider == 3'h0)
    |-> cnt_tick)
    else $error("Divide by one missed a tick.");

  div_top_a: assert property (cnt_tick && (st_r.counter_clock_divider == 3'h7)
    |-> st_r.presc == 7'h7F)
    else $error("Divide by 128 ticked early.");

  cpu_clock_a: assert property (st_r.counter_run_enable && !st_r.ext_clock_select
    && !halt_mode |-> in_tick)
    else $error("CPU clock tick missing.");

  ext_clock_a: assert property (st_r.ext_clock_select && !ext_rise |-> !in_tick)
    else $error("Tick without external edge.");

  run_gate_a: assert property (!st_r.counter_run_enable |-> !in_tick)
    else $error("Tick while stopped.");

  frl_zero_a: assert property (setup && (idx == IDX_CSR)
    |=> !st_r.rdata[CSR_FRL_BIT])
    else $error("Force reload bit read as one.");

  cap_rsvd_a: assert property (setup && (idx == IDX_CAPCSR)
    |=> st_r.rdata[7:6] == 2'b00)
    else $error("Reserved capture bits read as one.");

  pwm_off_a: assert property (!st_r.out_enable[0]
    |-> !pulse_output_pin.level[0])
    else $error("Disabled output drives high.");

  pwm_low_cmp_a: assert property ((st_r.cnt <= st_r.compare_shadow[1])
    && !st_r.channel_polarity[1] |-> st_r.pwm[1])
    else $error("Output low at or below compare.");

  pwm_high_cmp_a: assert property ((st_r.cnt > st_r.compare_shadow[1])
    && !st_r.channel_polarity[1] |-> !st_r.pwm[1])
    else $error("Output high above compare.");

  shadow_hold_a: assert property (!(cnt_tick && (st_r.cnt == CNT_TOP))
    |=> $stable(st_r.compare_shadow))
    else $error("Compare shadow changed between overflows.");

  ovf_pwm_a: assert property (ovf_evt && !wr_ok |=> st_r.pwm[2] ==
    (($past(st_r.reload) <= $past(st_r.duty[2])) ^ $past(st_r.channel_polarity[2])))
    else $error("Output not set at overflow.");

  edge_sel_a: assert property (cap_edge_hit[1]
    |-> st_r.cap_sync[1][1] == st_r.cap_edge[1])
    else $error("Capture on the wrong edge.");

  ext_once_a: assert property (ext_rise |=> !ext_rise)
    else $error("External edge counted twice.");

  cap_once_a: assert property (cap_edge_hit[0] && !(wr_ok && (idx == IDX_CAPCSR))
    |=> !cap_edge_hit[0])
    else $error("Capture edge seen twice.");

  halt_ctl_a: assert property (halt_mode && acc_wr |=> $stable(st_r.counter_run_enable)
    && $stable(st_r.ext_clock_select))
    else $error("Control bits changed in halt.");

  halt_count_a: assert property (halted_ext && st_r.counter_run_enable && ext_rise
    && (st_r.counter_clock_divider == 3'h0) |-> cnt_tick)
    else $error("Counter stalled in halt.");

  cap_wake_ch1_a: assert property (halt_mode && st_r.capture_flag[1]
    && st_r.capture_irq_enable[1] |-> wake_req)
    else $error("Capture two failed to wake.");

  wake_halt_a: assert property (!halt_mode |-> !wake_req)
    else $error("Wake raised outside halt.");

endmodule

// File: hw/art_timer_pkg.sv
// Purpose: Constants and state layout for the auto-reload PWM and capture timer.
// Assumes: APB slave, 32-bit data, one byte register per aligned word.
// Notes:   Register indices are kept as printed; byte address is four times the index.
// Behaviour
// - In halt with external clock, control registers stay frozen, counter keeps counting.
// - In halt with external clock and overflow enable, next overflow raises wake.
// - Selected capture edge copies counter into capture data and sets capture flag.
// - Interrupt stays asserted while an enabled channel's capture flag is set.
// - After a capture, capture data is not updated again until read.
// - Capture inputs double as edge interrupts that wake the processor from halt.
// - Control bit 7 selects CPU clock (0) or external clock (1).
// - Bits 6:4 divide the input clock by two to the field value.
// - Run enable bit 3 freezes prescaler and counter when clear.
// - Writing force reload bit 2 loads reload value, clears prescaler, reads zero.
// - Overflow request only while overflow flag and its enable are set.
// - Overflow flag set on FFh to reload, cleared by reading control/status.
// - Counter access register reads live count; a write replaces the count.
// - Overflow reloads counter and sets every PWM output to its polarity level; the code does so only where duty is at or above the reload value.
// - PWM control bits 7:4 enable each PWM output pin independently.
// - Output high while counter at or below compare, inverted by polarity bit.
// - A polarity change inverts the PWM output at once.
// - Duty register sets second edge; reload value sets the common first edge.
// - Capture control/status bits 7:6 always read as zero.
// - Capture edge bits 5:4 choose falling (0) or rising (1) edge.
// - Capture interrupt enable bits 3:2 gate each channel's interrupt.
// - Capture flags set by hardware, cleared by reading that channel's data.
// - Counter advances by one on each prescaler output tick.
// - Hidden compare registers load from duty registers only at overflow.
// - Forced reload or counter write also clears the 7-bit prescaler.
package art_timer_pkg;

  // Register indices, byte address is index times four.
  localparam logic [9:0] IDX_DUTY3   = 10'h073;
  localparam logic [9:0] IDX_DUTY0   = 10'h076;
  localparam logic [9:0] IDX_PWMCTL  = 10'h077;
  localparam logic [9:0] IDX_CSR     = 10'h078;
  localparam logic [9:0] IDX_CNT     = 10'h079;
  localparam logic [9:0] IDX_RELOAD  = 10'h07A;
  localparam logic [9:0] IDX_CAPCSR  = 10'h07B;
  localparam logic [9:0] IDX_CAP1    = 10'h07C;
  localparam logic [9:0] IDX_CAP2    = 10'h07D;

  // Field positions in the timer control/status register.
  localparam int CSR_EXT_CLOCK_SELECT_BIT  = 7;
  localparam int CSR_DIV_LSB   = 4;
  localparam int CSR_RUN_BIT   = 3;
  localparam int CSR_FRL_BIT   = 2;
  localparam int CSR_OIE_BIT   = 1;
  localparam int CSR_OVF_BIT   = 0;

  // Field positions in the capture control/status register.
  localparam int CAP_EDGE_LSB  = 4;
  localparam int CAP_IE_LSB    = 2;
  localparam int CAP_FLAG_LSB  = 0;

  // Values after reset and fixed counts.
  localparam logic [7:0] BYTE_RST    = 8'h00;
  localparam logic [7:0] CNT_TOP     = 8'hFF;
  localparam logic [6:0] PRESC_RST   = 7'h00;
  // Count and compare both clear to zero, so a channel sits at or below compare.
  localparam logic [3:0] PWM_RST     = 4'hF;
  localparam int         PWM_CHANS   = 4;
  localparam int         CAP_CHANS   = 2;

  // Whole state of the timer, registered as one word.
  typedef struct packed {
    logic             ext_clock_select;
    logic [2:0]       counter_clock_divider;
    logic             counter_run_enable;
    logic             overflow_irq_enable;
    logic             overflow_flag;
    logic [7:0]       cnt;
    logic [7:0]       reload;
    logic [3:0]       out_enable;
    logic [3:0]       channel_polarity;
    logic [3:0][7:0]  duty;
    logic [3:0][7:0]  compare_shadow;
    logic [1:0]       cap_edge;
    logic [1:0]       capture_irq_enable;
    logic [1:0]       capture_flag;
    logic [1:0][7:0]  capture_data;
    logic [6:0]       presc;
    logic [2:0]       ext_sync;
    logic [1:0][2:0]  cap_sync;
    logic [3:0]       pwm;
    logic [31:0]      rdata;
    logic             err;
  } state_t;

  // Pin group of the four PWM outputs.
  typedef struct packed {
    logic [3:0] level;
    logic [3:0] oe;
  } pwm_pins_t;

endpackage
